// >>> logic/twm_pkg.sv
// Constants, field layout and state types of the three-wire master.
package twm_pkg;
   // Register port
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 16;
   localparam logic [7:0]  OFS_CONTROL     = 8'h0A;
   localparam logic [7:0]  OFS_PACKET      = 8'h04;
   localparam logic [7:0]  CONTROL_RESET   = 8'h00;
   localparam logic [15:0] PACKET_RESET    = 16'h0000;
   // Control register fields
   localparam int          BIT_ENABLE      = 7;
   localparam int          BIT_PERIOD_HI   = 6;
   localparam int          BIT_PERIOD_LO   = 4;
   localparam int          BIT_IRQ_ENABLE  = 3;
   localparam int          BIT_CS_DISABLE  = 2;
   localparam int          BIT_DONE        = 1;
   localparam int          BIT_BUSY        = 0;
   // Packet fields
   localparam int          PKT_BITS        = 16;
   localparam int          PKT_RW_BIT      = 8;
   localparam int          PKT_HEAD_BITS   = 8;
   localparam logic [7:0]  READ_UPPER      = 8'h00;
   // Serial clock timing, default queue depth and last bit index
   localparam int          SCLK_BASE_NS    = 1000;
   localparam int          SCLK_STEP_NS    = 400;
   localparam int          LINK_CLK_NS     = 64;
   localparam int          FIFO_DEPTH_DEF  = 16;
   localparam logic [3:0]  LAST_BIT        = 4'hF;

   // Half period in link cycles, rounded up so the period is never short
   function automatic logic [7:0] twm_half_cycles(input logic [2:0] sel);
      int half_ns;
      half_ns = (SCLK_BASE_NS + SCLK_STEP_NS * int'(sel)) / 2;
      return 8'((half_ns + LINK_CLK_NS - 1) / LINK_CLK_NS);
   endfunction : twm_half_cycles

   typedef enum logic [1:0] {
      LINK_IDLE = 2'b00,
      LINK_LOW  = 2'b01,
      LINK_HIGH = 2'b10,
      LINK_END  = 2'b11
   } twm_link_st_t;

   typedef struct packed {
      logic        enable;
      logic [2:0]  period_sel;
      logic        irq_enable;
      logic        cs_disable;
      logic        done_flag;
      logic        busy;
   } twm_ctrl_t;

   typedef struct packed {
      logic [15:0] word;
      logic [2:0]  period_sel;
   } twm_job_t;

   typedef struct packed {
      logic        ok;
      logic        was_read;
      logic [7:0]  rx_byte;
   } twm_result_t;
endpackage : twm_pkg

// >>> logic/twm_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush input.
`timescale 1ns/100ps
module twm_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock, reset and flush
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [PW:0]   count;
   } twm_fifo_st_t;

   twm_fifo_st_t           st_reg;
   twm_fifo_st_t           st_next;
   logic [WIDTH-1:0]       mem [DEPTH];
   logic                   push;
   logic                   pop;

   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
      $error("twm_fifo depth must be a power of two of at least 2");
   end

   assign in_ready  = (st_reg.count != (PW+1)'(DEPTH));
   assign out_valid = (st_reg.count != '0);
   assign out_data  = mem[st_reg.rd_ptr];
   assign push      = in_valid && in_ready && !flush;
   assign pop       = out_valid && out_ready && !flush;

   always_comb begin
      st_next = st_reg;
      if (flush) begin
         st_next = '0;
      end else begin
         if (push) begin
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
         end
         if (pop) begin
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            st_next.count = st_reg.count + 1'b1;
         end else if (pop && !push) begin
            st_next.count = st_reg.count - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Storage has no reset; only words below the count are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[st_reg.wr_ptr] <= in_data;
      end
   end
endmodule : twm_fifo

// >>> logic/twm_master.sv
// Three-wire serial master: control register, command queue and link shifter.
`timescale 1ns/100ps
module twm_master #(
   parameter int FIFO_DEPTH = twm_pkg::FIFO_DEPTH_DEF
) (
   // Core clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       rst_n,
   // Special function register port
   input  wire logic [twm_pkg::ADDR_W-1:0] sfr_addr,
   input  wire logic                       sfr_wr_en,
   input  wire logic                       sfr_rd_en,
   input  wire logic [twm_pkg::DATA_W-1:0] sfr_wdata,
   output logic      [twm_pkg::DATA_W-1:0] sfr_rdata,
   output logic                            packet_ready,
   output logic                            done_irq,
   // Link clock
   input  wire logic                       link_clk,
   // Serial pins
   output logic                            serial_clock_out,
   output logic                            chip_select_out,
   output logic                            chip_select_oe,
   output logic                            sdio_out,
   output logic                            sdio_oe,
   input  wire logic                       sdio_in
);
   import twm_pkg::*;

   typedef struct packed {
      twm_ctrl_t   ctrl;
      logic [15:0] packet_word;
      logic [15:0] rdata;
      logic        irq;
      logic        ready;
      logic        pending;
      logic        req_tgl;
      twm_job_t    job;
      logic        ack_s1;
      logic        ack_s2;
      logic        ack_s3;
   } twm_core_st_t;

   typedef struct packed {
      twm_link_st_t state;
      logic [7:0]   cnt;
      logic [7:0]   half;
      logic [3:0]   bit_idx;
      logic [15:0]  shift;
      logic         is_read;
      logic         sclk;
      logic         cs;
      logic         cs_oe;
      logic         dout;
      logic         doe;
      logic         ack_tgl;
      twm_result_t  res;
      logic         req_s1;
      logic         req_s2;
      logic         req_s3;
      logic         en_s1;
      logic         en_s2;
      logic         dis_s1;
      logic         dis_s2;
      logic         din_s1;
      logic         din_s2;
   } twm_link_reg_t;

   twm_core_st_t  c_reg;
   twm_core_st_t  c_next;
   twm_link_reg_t l_reg;
   twm_link_reg_t l_next;

   logic          wr_ctrl;
   logic          wr_pkt;
   logic          push;
   logic          fifo_ready;
   logic          fifo_valid;
   logic          fifo_pop;
   logic [15:0]   fifo_data;
   logic          ack_evt;
   logic          req_evt;

   assign wr_ctrl  = sfr_wr_en && (sfr_addr == OFS_CONTROL);
   assign wr_pkt   = sfr_wr_en && (sfr_addr == OFS_PACKET);
   assign push     = wr_pkt && c_reg.ctrl.enable && fifo_ready;
   assign ack_evt  = c_reg.ack_s2 ^ c_reg.ack_s3;
   assign fifo_pop = c_reg.ctrl.enable && !c_reg.pending && fifo_valid;

   // Queue absorbs back-to-back packet writes; a full queue refuses the write
   twm_fifo #(
      .WIDTH (PKT_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_queue (
      .clk       (core_clk),
      .rst_n     (rst_n),
      .flush     (!c_reg.ctrl.enable),
      .in_valid  (wr_pkt),
      .in_ready  (fifo_ready),
      .in_data   (sfr_wdata),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // Core domain
   always_comb begin
      c_next        = c_reg;
      c_next.ack_s1 = l_reg.ack_tgl;
      c_next.ack_s2 = c_reg.ack_s1;
      c_next.ack_s3 = c_reg.ack_s2;
      c_next.ready  = fifo_ready && c_reg.ctrl.enable;
      if (wr_ctrl) begin
         c_next.ctrl.enable     = sfr_wdata[BIT_ENABLE];
         c_next.ctrl.period_sel = sfr_wdata[BIT_PERIOD_HI:BIT_PERIOD_LO];
         c_next.ctrl.irq_enable = sfr_wdata[BIT_IRQ_ENABLE];
         c_next.ctrl.cs_disable = sfr_wdata[BIT_CS_DISABLE];
         c_next.ctrl.done_flag  = sfr_wdata[BIT_DONE];
      end
      if (push) begin
         c_next.packet_word = sfr_wdata;
      end
      if (fifo_pop) begin
         c_next.pending        = 1'b1;
         c_next.req_tgl        = !c_reg.req_tgl;
         c_next.job.word       = fifo_data;
         c_next.job.period_sel = c_reg.ctrl.period_sel;
      end
      if (ack_evt) begin
         c_next.pending = 1'b0;
         if (l_reg.res.ok && c_reg.ctrl.enable) begin
            c_next.ctrl.done_flag = 1'b1;
            if (l_reg.res.was_read) begin
               c_next.packet_word = {READ_UPPER, l_reg.res.rx_byte};
            end
         end
      end
      // Software data never reaches the busy bit
      c_next.ctrl.busy = c_next.ctrl.enable
                         && (push || fifo_valid || c_next.pending);
      // Request follows the flag and enable one cycle later
      c_next.irq = c_reg.ctrl.done_flag && c_reg.ctrl.irq_enable;
      c_next.rdata = '0;
      if (sfr_rd_en && sfr_addr == OFS_CONTROL) begin
         c_next.rdata[7:0] = {c_reg.ctrl.enable, c_reg.ctrl.period_sel,
                              c_reg.ctrl.irq_enable, c_reg.ctrl.cs_disable,
                              c_reg.ctrl.done_flag, c_reg.ctrl.busy};
      end else if (sfr_rd_en && sfr_addr == OFS_PACKET) begin
         c_next.rdata = c_reg.packet_word;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         c_reg             <= '0;
         c_reg.ctrl        <= twm_ctrl_t'(CONTROL_RESET);
         c_reg.packet_word <= PACKET_RESET;
      end else begin
         c_reg <= c_next;
      end
   end

   assign req_evt = l_reg.req_s2 ^ l_reg.req_s3;

   // Link domain; the job word is held stable by the core until acknowledged
   always_comb begin
      l_next        = l_reg;
      l_next.req_s1 = c_reg.req_tgl;
      l_next.req_s2 = l_reg.req_s1;
      l_next.req_s3 = l_reg.req_s2;
      l_next.en_s1  = c_reg.ctrl.enable;
      l_next.en_s2  = l_reg.en_s1;
      l_next.dis_s1 = c_reg.ctrl.cs_disable;
      l_next.dis_s2 = l_reg.dis_s1;
      l_next.din_s1 = sdio_in;
      l_next.din_s2 = l_reg.din_s1;
      l_next.cs_oe  = !l_reg.dis_s2;
      l_next.cnt    = l_reg.cnt + 8'h01;
      unique case (l_reg.state)
         LINK_IDLE: begin
            l_next.cnt = 8'h00;
            if (req_evt && l_reg.en_s2) begin
               l_next.state   = LINK_LOW;
               l_next.half    = twm_half_cycles(c_reg.job.period_sel);
               l_next.shift   = c_reg.job.word;
               l_next.is_read = c_reg.job.word[PKT_RW_BIT];
               l_next.bit_idx = 4'h0;
               l_next.cs      = 1'b1;
               l_next.dout    = c_reg.job.word[PKT_BITS-1];
               l_next.doe     = 1'b1;
            end else if (req_evt) begin
               l_next.res.ok  = 1'b0;
               l_next.ack_tgl = !l_reg.ack_tgl;
            end
         end
         LINK_LOW: begin
            if (l_reg.cnt == l_reg.half - 8'h01) begin
               l_next.cnt   = 8'h00;
               l_next.sclk  = 1'b1;
               l_next.state = LINK_HIGH;
            end
         end
         LINK_HIGH: begin
            if (l_reg.cnt == l_reg.half - 8'h01) begin
               l_next.cnt   = 8'h00;
               l_next.sclk  = 1'b0;
               // Sample before shifting so the new bit lands in bit 0
               l_next.shift = {l_reg.shift[PKT_BITS-2:0],
                               l_reg.is_read ? l_reg.din_s2 : 1'b0};
               l_next.bit_idx = l_reg.bit_idx + 4'h1;
               l_next.dout    = l_reg.shift[PKT_BITS-2];
               if (l_reg.is_read && l_reg.bit_idx == 4'(PKT_HEAD_BITS - 1)) begin
                  l_next.doe = 1'b0;
               end
               if (l_reg.bit_idx == LAST_BIT) begin
                  l_next.state = LINK_END;
               end else begin
                  l_next.state = LINK_LOW;
               end
            end
         end
         LINK_END: begin
            l_next.state        = LINK_IDLE;
            l_next.cs           = 1'b0;
            l_next.doe          = 1'b0;
            l_next.dout         = 1'b0;
            l_next.res.ok       = 1'b1;
            l_next.res.was_read = l_reg.is_read;
            l_next.res.rx_byte  = l_reg.shift[7:0];
            l_next.ack_tgl      = !l_reg.ack_tgl;
         end
      endcase
      // Abort still acknowledges so the core never waits forever
      if (!l_reg.en_s2 && l_reg.state != LINK_IDLE) begin
         l_next.state   = LINK_IDLE;
         l_next.sclk    = 1'b0;
         l_next.cs      = 1'b0;
         l_next.doe     = 1'b0;
         l_next.dout    = 1'b0;
         l_next.res.ok  = 1'b0;
         l_next.ack_tgl = !l_reg.ack_tgl;
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         l_reg <= '0;
      end else begin
         l_reg <= l_next;
      end
   end

   assign sfr_rdata        = c_reg.rdata;
   assign packet_ready     = c_reg.ready;
   assign done_irq         = c_reg.irq;
   assign serial_clock_out = l_reg.sclk;
   assign chip_select_out  = l_reg.cs;
   assign chip_select_oe   = l_reg.cs_oe;
   assign sdio_out         = l_reg.dout;
   assign sdio_oe          = l_reg.doe;

   AST_IRQ_GATE: assert property (@(posedge core_clk) disable iff (!rst_n)
      done_irq |-> $past(c_reg.ctrl.done_flag && c_reg.ctrl.irq_enable))
      else $error("interrupt without flag and enable");

   AST_BUSY_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
      !c_reg.ctrl.enable |-> !c_reg.ctrl.busy)
      else $error("busy while disabled");

   AST_BUSY_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
      (push && !(wr_ctrl && !sfr_wdata[BIT_ENABLE])) |=> c_reg.ctrl.busy)
      else $error("busy not set by packet write");

   AST_FLAG_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
      (c_reg.ctrl.done_flag && !wr_ctrl) |=> c_reg.ctrl.done_flag)
      else $error("done flag lost without software clear");

   AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ack_evt && l_reg.res.ok && c_reg.ctrl.enable) |=> c_reg.ctrl.done_flag)
      else $error("done flag not set at transfer end");

   AST_ABORT: assert property (@(posedge link_clk) disable iff (!rst_n)
      (!l_reg.en_s2 && l_reg.state != LINK_IDLE)
      |=> (l_reg.state == LINK_IDLE && !l_reg.sclk && !l_reg.cs && !l_reg.doe))
      else $error("disable did not abort the link");

   AST_READ_RELEASE: assert property (@(posedge link_clk) disable iff (!rst_n)
      (l_reg.state == LINK_LOW && l_reg.is_read && l_reg.bit_idx >= 4'h8)
      |-> !l_reg.doe)
      else $error("data line driven during read data phase");

   AST_CS_FRAME: assert property (@(posedge link_clk) disable iff (!rst_n)
      (l_reg.state == LINK_IDLE && req_evt && l_reg.en_s2)
      |=> (l_reg.cs && l_reg.doe) [*2])
      else $error("chip select not raised at transfer start");

   AST_HALF_PERIOD: assert property (@(posedge link_clk) disable iff (!rst_n)
      (l_reg.state == LINK_LOW && $rose(l_reg.sclk) == 1'b0 && $past(l_reg.state) == LINK_HIGH)
      |-> $past(l_reg.cnt) == l_reg.half - 8'h01)
      else $error("serial clock half period wrong");
endmodule : twm_master

// >>> tb/twm_slave_model.sv
// Behavioural model of the serial slave device on the three-wire link.
`timescale 1ns/100ps
module twm_slave_model (
   // Reset and link pins
   input  wire logic  rst_n,
   input  wire logic  sclk,
   input  wire logic  cs,
   input  wire logic  sdio,
   // Data the slave returns on reads
   input  wire logic [7:0] reply,
   // Slave drive of the data line
   output logic       drive_oe,
   output logic       drive_val,
   // Observations
   output logic [15:0] rx_word,
   output int          rx_cnt,
   output realtime     period,
   output logic        cs_ok
);
   int          n;
   logic        rw;
   logic [15:0] sh;
   realtime     t_rise;

   initial begin
      n = 0;
      rx_cnt = 0;
      drive_oe = 1'b0;
      drive_val = 1'b0;
      cs_ok = 1'b1;
      t_rise = 0;
      rw = 1'b0;
   end

   // Chip select low frames out the packet, so a cut-short frame is dropped
   always @(negedge cs or negedge rst_n) begin
      n = 0;
      drive_oe = 1'b0;
   end

   // Master bits taken on the rise, MSB first; reply driven on rises 9 to 16
   always @(posedge sclk) begin
      period = $realtime - t_rise;
      t_rise = $realtime;
      if (n == 0) cs_ok = 1'b1;
      if (!cs) cs_ok = 1'b0;
      n++;
      if (n <= 8 || !rw) sh = {sh[14:0], sdio};
      if (n == 8) rw = sh[0];
      if (n >= 9 && rw) begin
         drive_oe = 1'b1;
         drive_val = reply[16-n];
      end
      if (n == 16 && !rw) begin
         rx_word = sh;
         rx_cnt++;
      end
   end

   // Reply bits are seen on the wire at the fall, where the master samples them
   always @(negedge sclk) begin
      if (n >= 9 && rw) sh = {sh[14:0], sdio};
      if (n == 16) begin
         if (rw) begin
            rx_word = sh;
            rx_cnt++;
         end
         n = 0;
         drive_oe = 1'b0;
      end
   end
endmodule : twm_slave_model

// >>> tb/twm_master_bench.sv
// Self-checking bench of the three-wire master against a slave model.
`timescale 1ns/100ps
module twm_master_bench;
   import twm_pkg::*;
   logic        core_clk, rst_n, link_clk, sfr_wr_en, sfr_rd_en, gpio_cs;
   logic        flip = 1'b0;
   logic [7:0]  sfr_addr, reply, ctl;
   logic [15:0] sfr_wdata, sfr_rdata, rx_word, v, w;
   logic        packet_ready, done_irq, serial_clock_out, chip_select_out;
   logic        chip_select_oe, sdio_out, sdio_oe, slv_oe, slv_val, cs_ok;
   int          num_errors, comparisons, rx_cnt, half, acc, k, prev;
   realtime     period;
   logic [31:0] seed = 32'h62;
   logic [15:0] sent[$];
   logic [15:0] got[$];
   // Released line gets a moving pattern so a stale bit cannot pass
   wire logic   sdio_wire = sdio_oe ? sdio_out : (slv_oe ? slv_val : flip);
   wire logic   cs_wire = chip_select_oe ? chip_select_out : gpio_cs;

   twm_master #(.FIFO_DEPTH(16)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .packet_ready(packet_ready),
      .done_irq(done_irq), .link_clk(link_clk), .serial_clock_out(serial_clock_out),
      .chip_select_out(chip_select_out), .chip_select_oe(chip_select_oe),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdio_in(sdio_wire));

   twm_slave_model slave_u (.rst_n(rst_n), .sclk(serial_clock_out), .cs(cs_wire),
      .sdio(sdio_wire), .reply(reply), .drive_oe(slv_oe), .drive_val(slv_val),
      .rx_word(rx_word), .rx_cnt(rx_cnt), .period(period), .cs_ok(cs_ok));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #32 link_clk = ~link_clk;
   end
   always @(posedge link_clk) flip <= ~flip;
   always @(rx_cnt) got.push_back(rx_word);

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge core_clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr_en = 1'b1;
      @(negedge core_clk);
      sfr_wr_en = 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge core_clk);
      sfr_addr = a;
      sfr_rd_en = 1'b1;
      @(negedge core_clk);
      sfr_rd_en = 1'b0;
      d = sfr_rdata;
   endtask : reg_rd

   task automatic xfer(input logic [15:0] pw, input logic [7:0] c);
      logic [15:0] r;
      int          n;
      reg_wr(OFS_PACKET, pw);
      reg_rd(OFS_CONTROL, r);
      chk("busy_set", {8'h00, c | 8'h01}, r);
      n = 0;
      while (sdio_oe !== 1'b1 && n < 30) begin
         @(negedge core_clk);
         n++;
      end
      chk("start", 16'h0001, 16'(sdio_oe));
      chk("cs_drive", 16'(!c[2]), 16'(chip_select_oe));
      n = 0;
      do begin
         reg_rd(OFS_CONTROL, r);
         n++;
      end while (r[0] !== 1'b0 && n < 10000);
      chk("done", {8'h00, c | 8'h02}, r);
      chk("cs_low", 16'h0000, 16'(chip_select_out));
   endtask : xfer

   task automatic finish_test();
      if (num_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   initial begin
      #1500000;
      num_errors++;
      finish_test();
   end

   initial begin
      rst_n = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 16'h0000;
      sfr_wr_en = 1'b0;
      sfr_rd_en = 1'b0;
      gpio_cs = 1'b0;
      reply = 8'h00;
      num_errors = 0;
      comparisons = 0;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      rst_n = 1'b1;
      reg_rd(OFS_CONTROL, v);
      chk("ctrl_reset", 16'h0000, v);
      reg_rd(OFS_PACKET, v);
      chk("pkt_reset", 16'h0000, v);
      reg_rd(8'h33, v);
      chk("unmapped", 16'h0000, v);
      // Packet write while disabled must not start anything
      reg_wr(OFS_PACKET, 16'h1234);
      repeat (60) @(negedge core_clk);
      reg_rd(OFS_CONTROL, v);
      chk("off_busy", 16'h0000, v);
      chk("off_link", 16'h0000, 16'(rx_cnt + int'(sdio_oe)));
      // Every clock period code, reads on odd codes, interrupt on odd codes
      for (int s = 0; s < 8; s++) begin
         ctl = 8'h80 | 8'(s << 4) | (s[0] ? 8'h08 : 8'h00) | (s == 5 ? 8'h04 : 8'h00);
         gpio_cs = (s == 5);
         reg_wr(OFS_CONTROL, {8'h00, ctl | 8'h01});
         reg_rd(OFS_CONTROL, v);
         chk("ctrl", {8'h00, ctl}, v);
         w = 16'(rnd());
         w[8] = s[0];
         reply = 8'(rnd());
         xfer(w, ctl);
         half = ((1000 + 400 * s) / 2 + 63) / 64;
         chk("period", 16'(128 * half), 16'(int'(period)));
         chk("wire_word", s[0] ? {w[15:8], reply} : w, rx_word);
         chk("cs_held", 16'h0001, 16'(cs_ok));
         reg_rd(OFS_PACKET, v);
         if (s[0]) begin
            chk("rd_result", {8'h00, reply}, v);
         end else begin
            chk("wr_keep", w, v);
         end
         repeat (3) @(negedge core_clk);
         chk("irq", 16'(s[0]), 16'(done_irq));
         reg_rd(OFS_CONTROL, v);
         chk("done_hold", {8'h00, ctl | 8'h02}, v);
         reg_wr(OFS_CONTROL, {8'h00, (ctl & 8'hF7) | 8'h02});
         repeat (3) @(negedge core_clk);
         chk("irq_mask", 16'h0000, 16'(done_irq));
         reg_wr(OFS_CONTROL, {8'h00, ctl});
         reg_rd(OFS_CONTROL, v);
         chk("done_clr", {8'h00, ctl}, v);
      end
      gpio_cs = 1'b0;
      // Abort in mid-packet by clearing enable
      prev = rx_cnt;
      reg_wr(OFS_CONTROL, 16'h00F0);
      xfer_abort: begin
         reg_wr(OFS_PACKET, 16'hA55A);
         repeat (300) @(negedge core_clk);
         reg_wr(OFS_CONTROL, 16'h0070);
         repeat (20) @(negedge core_clk);
      end
      chk("abort_pins", 16'h0000, 16'({serial_clock_out, sdio_oe, chip_select_out}));
      reg_rd(OFS_CONTROL, v);
      chk("abort_ctrl", 16'h0070, v);
      chk("abort_cnt", 16'(prev), 16'(rx_cnt));
      // Fill the queue until it refuses, then let it drain in order
      got.delete();
      reg_wr(OFS_CONTROL, 16'h0080);
      // Ready is registered from the enable of the cycle before
      @(negedge core_clk);
      acc = 0;
      while (packet_ready === 1'b1 && acc < 40) begin
         w = 16'(rnd()) & 16'hFEFF;
         reg_wr(OFS_PACKET, w);
         sent.push_back(w);
         acc++;
         repeat (2) @(negedge core_clk);
      end
      chk("fill", 16'h0001, 16'(acc >= 16));
      chk("full", 16'h0000, 16'(packet_ready));
      k = 0;
      while (got.size() < acc && k < 30000) begin
         @(negedge core_clk);
         k++;
      end
      chk("drain_cnt", 16'(acc), 16'(got.size()));
      foreach (sent[i]) chk("drain_word", sent[i], got[i]);
      // Last fall, end state and acknowledge crossing trail the slave's last rise
      repeat (60) @(negedge core_clk);
      reg_rd(OFS_CONTROL, v);
      chk("drain_ctrl", 16'h0082, v);
      finish_test();
   end
endmodule : twm_master_bench
